// ===== irc_top.sv
// initial-reset controller: sources, release latch, cpu reset state
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module irc_top
    import irc_pkg::*;
#(
    parameter int KEY_OPT   = 1,
    parameter int SUP_OPT   = 4,
    parameter bit TIME_AUTH = 1'b0,
    parameter int AUTH_TCK  = IRC_AUTH_TCK
)
(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic        reset_n_i,
    input  wire logic [3:0]  key_in_i,
    input  wire logic        low_speed_osc_i,
    input  wire logic        supply_low_i,
    input  wire logic        step_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output var  logic [7:0]  rdata_o,
    output var  logic        init_reset_o,
    output var  logic [15:0] pc_o,
    output var  logic        int_flag_o,
    output var  logic        ext_flag_o,
    output var  logic        int_allow_o,
    output var  logic [3:0]  out_pin_o,
    output var  logic [3:0]  bidir_oe_o,
    output var  logic [3:0]  bidir_pull_o,
    output var  logic [10:0] sup_level_mv_o
);
    // refuse option codes the logic has no meaning for
    initial
    begin
        if (KEY_OPT < 1 || KEY_OPT > 4)
            $error("irc_top: KEY_OPT must be 1 to 4");
        if (SUP_OPT < 1 || SUP_OPT > 4)
            $error("irc_top: SUP_OPT must be 1 to 4");
        if (AUTH_TCK < 2 || AUTH_TCK > 65535)
            $error("irc_top: AUTH_TCK out of range");
    end

    // ---- low-speed tick and 16 Hz divider ----
    logic                 osc_q_r;
    logic [IRC_DIV_W-1:0] div_r;
    logic [IRC_DIV_W-1:0] div_nxt;
    wire                  osc_tick_w;
    wire                  phase_hi_w;

    // rising edge of the slow clock; no edges means no counting
    assign osc_tick_w = low_speed_osc_i & ~osc_q_r;
    assign div_nxt    = div_r + IRC_DIV_W'(osc_tick_w);
    // top bit: 1024 ticks high, 1024 low, i.e. 16 Hz at 32.768 kHz
    assign phase_hi_w = div_r[IRC_DIV_W-1]; // [R4]

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            osc_q_r <= 1'b0;
            div_r   <= '0;
        end
        else
        begin
            osc_q_r <= low_speed_osc_i;
            div_r   <= div_nxt;
        end
    end

    // ---- key combination source ----
    wire [3:0] key_mask_w;
    wire       keys_low_w;
    wire       filt_met_w;
    wire       auth_met_w;
    wire       key_req_w;

    // option 1 gives an empty mask, so nothing ever matches
    assign key_mask_w = (KEY_OPT == 2) ? IRC_KEY_M2 :
                        (KEY_OPT == 3) ? IRC_KEY_M3 :
                        (KEY_OPT == 4) ? IRC_KEY_M4 : 4'h0; // [R5]
    // unselected keys are masked away
    assign keys_low_w = (key_mask_w != 4'h0) &&
                        ((~key_in_i & key_mask_w) == key_mask_w); // [R6]

    // noise filter: about 1.5 ms of continuous low
    irc_lowtime
    #(
        .CNT_W (8),
        .COUNT (IRC_FILT_TCK)
    )
    u_filt
    (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .tick_i (osc_tick_w),
        .cond_i (keys_low_w),
        .met_o  (filt_met_w)
    ); // [R7]

    // long-press qualifier counts on after the filter has passed
    irc_lowtime
    #(
        .CNT_W (16),
        .COUNT (AUTH_TCK)
    )
    u_auth
    (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .tick_i (osc_tick_w),
        .cond_i (filt_met_w),
        .met_o  (auth_met_w)
    ); // [R9]

    assign key_req_w = TIME_AUTH ? auth_met_w : filt_met_w; // [R9]

    // ---- supply monitor source ----
    wire sup_req_w;

    // the comparator itself is analog; only its verdict arrives here
    assign sup_req_w = (SUP_OPT != 4) && supply_low_i; // [R10] [R12]

    // ---- reset latch ----
    logic rst_latch_r;
    wire  pin_req_w;
    wire  any_req_w;
    wire  latch_nxt;

    assign pin_req_w = ~reset_n_i; // [R2]
    assign any_req_w = pin_req_w | key_req_w | sup_req_w; // [R18] [R1]
    // set wins over the release phase, so no request is lost
    assign latch_nxt = any_req_w ? 1'b1 :
                       phase_hi_w ? 1'b0 : rst_latch_r; // [R3] [R4]

    // latch comes up set so the chip starts in reset
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            rst_latch_r <= 1'b1;
        else
            rst_latch_r <= latch_nxt; // [R3]
    end

    // ---- register decode ----
    wire wr_spw_w;
    wire wr_spn_w;
    wire wr_ext_w;
    wire wr_flg_w;
    wire wr_out_w;
    wire wr_dir_w;
    wire sw_ok_w;

    // cpu-side writes are ignored while reset is held
    assign sw_ok_w  = wr_i && !rst_latch_r;
    assign wr_spw_w = sw_ok_w && (addr_i == IRC_ADR_SPW);
    assign wr_spn_w = sw_ok_w && (addr_i == IRC_ADR_SPN);
    assign wr_ext_w = sw_ok_w && (addr_i == IRC_ADR_EXT);
    assign wr_flg_w = sw_ok_w && (addr_i == IRC_ADR_FLAGS);
    assign wr_out_w = sw_ok_w && (addr_i == IRC_ADR_OUT);
    assign wr_dir_w = sw_ok_w && (addr_i == IRC_ADR_DIR);

    // ---- stack pointers and interrupt mask ----
    logic [7:0] spw_r;
    logic [7:0] spn_r;
    logic       spw_set_r;
    logic       spn_set_r;
    wire        both_set_w;

    assign both_set_w = spw_set_r & spn_set_r;

    // re-writing one pointer when both are set masks again
    // until the other one is written as well
    always_ff @(posedge mclk_i)
    begin
        if (srst_i || rst_latch_r)
        begin
            spw_set_r <= 1'b0; // [R15]
            spn_set_r <= 1'b0; // [R15]
        end
        else if (wr_spw_w)
        begin
            spw_set_r <= 1'b1;
            if (both_set_w)
                spn_set_r <= 1'b0;
        end
        else if (wr_spn_w)
        begin
            spn_set_r <= 1'b1;
            if (both_set_w)
                spw_set_r <= 1'b0;
        end
    end

    // pointer values themselves stay undefined at reset
    always_ff @(posedge mclk_i)
    begin
        if (wr_spw_w)
            spw_r <= wdata_i;
        if (wr_spn_w)
            spn_r <= wdata_i;
    end

    // ---- program counter and flags ----
    logic int_nxt;
    logic ext_nxt;

    // extension flag lives for one instruction; a write wins
    assign ext_nxt = wr_ext_w ? 1'b1 :
                     step_i ? 1'b0 : ext_flag_o; // [R16]
    assign int_nxt = wr_flg_w ? wdata_i[0] : int_flag_o;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i || rst_latch_r)
        begin
            pc_o       <= IRC_PC_RST; // [R13]
            int_flag_o <= 1'b0; // [R14]
            ext_flag_o <= 1'b0; // [R14]
        end
        else
        begin
            if (step_i)
                pc_o <= pc_o + 16'h0001;
            int_flag_o <= int_nxt;
            ext_flag_o <= ext_nxt;
        end
    end

    // interrupts are allowed once both pointers are set, a cycle later
    always_ff @(posedge mclk_i)
    begin
        if (srst_i || rst_latch_r)
            int_allow_o <= 1'b0; // [R15]
        else
            int_allow_o <= both_set_w; // [R15]
    end

    // ---- port pins ----
    // pull-ups follow input mode; off once the pin is driven
    always_ff @(posedge mclk_i)
    begin
        if (srst_i || rst_latch_r)
        begin
            out_pin_o    <= IRC_OUT_RST; // [R17]
            bidir_oe_o   <= IRC_DIR_RST; // [R17]
            bidir_pull_o <= IRC_PULL_RST; // [R17]
        end
        else
        begin
            if (wr_out_w)
                out_pin_o <= wdata_i[3:0];
            if (wr_dir_w)
            begin
                bidir_oe_o   <= wdata_i[3:0];
                bidir_pull_o <= ~wdata_i[3:0];
            end
        end
    end

    // ---- supply threshold report ----
    wire [10:0] sup_mv_w;

    // 0 means the monitor is not fitted
    assign sup_mv_w = (SUP_OPT == 1) ? 11'(IRC_SUP_MV1) :
                      (SUP_OPT == 2) ? 11'(IRC_SUP_MV2) :
                      (SUP_OPT == 3) ? 11'(IRC_SUP_MV3) : 11'h000; // [R11]

    // internal reset output and the threshold report
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            init_reset_o   <= 1'b1;
            sup_level_mv_o <= 11'h000;
        end
        else
        begin
            init_reset_o   <= rst_latch_r; // [R3]
            sup_level_mv_o <= sup_mv_w;
        end
    end

    // ---- read path ----
    wire [7:0] status_w;
    wire [7:0] rd_mux_w;

    assign status_w[IRC_ST_RST] = rst_latch_r;
    assign status_w[IRC_ST_SPW] = spw_set_r;
    assign status_w[IRC_ST_SPN] = spn_set_r;
    assign status_w[IRC_ST_IEN] = both_set_w;
    assign status_w[IRC_ST_EXT] = ext_flag_o;
    assign status_w[IRC_ST_INT] = int_flag_o;
    assign status_w[IRC_ST_KEY] = key_req_w;
    assign status_w[IRC_ST_SUP] = sup_req_w;

    // unmapped addresses read as zero
    assign rd_mux_w =
        (addr_i == IRC_ADR_STATUS) ? status_w :
        (addr_i == IRC_ADR_SPW)    ? spw_r :
        (addr_i == IRC_ADR_SPN)    ? spn_r :
        (addr_i == IRC_ADR_FLAGS)  ? {7'h00, int_flag_o} :
        (addr_i == IRC_ADR_OUT)    ? {4'h0, out_pin_o} :
        (addr_i == IRC_ADR_DIR)    ? {4'h0, bidir_oe_o} : 8'h00;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge mclk_i)
    begin
        if (srst_i || !rd_i)
            rdata_o <= 8'h00;
        else
            rdata_o <= rd_mux_w;
    end
endmodule
`default_nettype wire

// ===== irc_pkg.sv
// constants, register map and option codes of the initial-reset controller
// Behaviour
// [R1] reset comes from the pin, a key combination and a supply monitor
// [R2] pin low holds reset; pin high releases it and the cpu then runs
// [R3] every reset request is caught in a set/reset latch driving internal reset
// [R4] latch clears only in the high phase of the 16 Hz divided tick
// [R5] key option: 1 off, 2 all four keys, 3 keys 0-2, 4 keys 0-1
// [R6] selected keys all low trigger reset, other keys are ignored
// [R7] key request is accepted only after about 1.5 ms of low time
// [R8] the key low-time count advances only on low-speed oscillator ticks
// [R9] optional time qualifier demands the keys stay low for 1 s or more
// [R10] supply monitor holds reset until release level and below reset level
// [R11] monitor option selects 1.8, 1.6 or 1.4 volt pair, or not used
// [R12] with the monitor not used it never causes a reset
// [R13] initial reset loads the program counter with 0110H
// [R14] initial reset clears the interrupt and extension flags
// [R15] all interrupts masked until both stack pointers are written
// [R16] writing the extension register sets the extension flag
// [R17] after reset outputs drive high, bidir pins are inputs with pull-ups
// [R18] all enabled sources are ored together to set the latch
package irc_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] IRC_ADR_STATUS = 8'h00;
    localparam logic [7:0] IRC_ADR_SPW    = 8'h04;
    localparam logic [7:0] IRC_ADR_SPN    = 8'h08;
    localparam logic [7:0] IRC_ADR_EXT    = 8'h0C;
    localparam logic [7:0] IRC_ADR_FLAGS  = 8'h10;
    localparam logic [7:0] IRC_ADR_OUT    = 8'h14;
    localparam logic [7:0] IRC_ADR_DIR    = 8'h18;
    // status field positions
    localparam int IRC_ST_RST  = 0;
    localparam int IRC_ST_SPW  = 1;
    localparam int IRC_ST_SPN  = 2;
    localparam int IRC_ST_IEN  = 3;
    localparam int IRC_ST_EXT  = 4;
    localparam int IRC_ST_INT  = 5;
    localparam int IRC_ST_KEY  = 6;
    localparam int IRC_ST_SUP  = 7;
    // values after reset
    localparam logic [15:0] IRC_PC_RST   = 16'h0110;
    localparam logic [3:0]  IRC_OUT_RST  = 4'hF;
    localparam logic [3:0]  IRC_DIR_RST  = 4'h0;
    localparam logic [3:0]  IRC_PULL_RST = 4'hF;
    // key option masks, index is option number
    localparam logic [3:0] IRC_KEY_M2 = 4'hF;
    localparam logic [3:0] IRC_KEY_M3 = 4'h7;
    localparam logic [3:0] IRC_KEY_M4 = 4'h3;
    // supply monitor thresholds in millivolts
    localparam int IRC_SUP_MV1 = 1800;
    localparam int IRC_SUP_MV2 = 1600;
    localparam int IRC_SUP_MV3 = 1400;
    // low-speed clock and divider
    localparam int IRC_OSC_HZ  = 32768;
    localparam int IRC_DIV_W   = 11;
    // key filter time and its count of oscillator ticks, rounded up
    localparam int IRC_FILT_US  = 1500;
    localparam int IRC_FILT_TCK =
        (IRC_FILT_US * IRC_OSC_HZ + 999999) / 1000000;
    // time qualifier least time in seconds
    localparam int IRC_AUTH_S   = 1;
    localparam int IRC_AUTH_TCK = IRC_AUTH_S * IRC_OSC_HZ;
endpackage

// ===== irc_lowtime.sv
// counts low-speed ticks while a condition holds and flags the target
`timescale 1ns/100ps
`default_nettype none
module irc_lowtime
#(
    parameter int CNT_W = 16,
    parameter int COUNT = 50
)
(
    input  wire logic mclk_i,
    input  wire logic srst_i,
    input  wire logic tick_i,
    input  wire logic cond_i,
    output var  logic met_o
);
    initial
    begin
        if (COUNT < 1 || COUNT >= (1 << CNT_W))
            $error("irc_lowtime: COUNT does not fit CNT_W");
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    wire              last_w;

    // a single high bounce restarts the whole window
    assign last_w = (cnt_r == CNT_W'(COUNT - 1));
    assign cnt_nxt = !cond_i ? '0 :
                     (tick_i && !met_o) ? cnt_r + 1'b1 : cnt_r;

    // only oscillator ticks advance the count
    always_ff @(posedge mclk_i)
    begin
        if (srst_i || !cond_i)
        begin
            cnt_r <= '0;
            met_o <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            if (tick_i && last_w)
                met_o <= 1'b1; // [R8]
        end
    end
endmodule
`default_nettype wire

// ===== irc_board_model.sv
// board side model: low-speed crystal and reset pin driver
`timescale 1ns/100ps
`default_nettype none
module irc_board_model
#(
    parameter int HALF = 4
)
(
    input  wire logic mclk_i,
    input  wire logic run_i,
    input  wire logic pin_low_i,
    output var  logic osc_o,
    output var  logic reset_n_o
);
    logic [7:0] cnt_r;
    // crystal is dead until powered, so no tick can reach the filter early
    initial
    begin
        cnt_r = 8'h00;
        osc_o = 1'b0;
    end
    // free-running once started; kept slower than half the main clock
    always @(posedge mclk_i)
    begin
        if (run_i)
        begin
            cnt_r <= (cnt_r == 8'(HALF - 1)) ? 8'h00 : cnt_r + 8'h01;
            if (cnt_r == 8'(HALF - 1))
                osc_o <= ~osc_o;
        end
    end
    // pin low asks for reset, pin high lets it go
    always_comb
        reset_n_o = ~pin_low_i;
endmodule
`default_nettype wire

// ===== irc_top_monitor.sv
// port checker of the initial-reset controller
`timescale 1ns/100ps
`default_nettype none
module irc_top_monitor
    import irc_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        srst_i,
    input wire logic        reset_n_i,
    input wire logic [3:0]  key_in_i,
    input wire logic        low_speed_osc_i,
    input wire logic        supply_low_i,
    input wire logic        step_i,
    input wire logic [7:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        init_reset_o,
    input wire logic [15:0] pc_o,
    input wire logic        int_flag_o,
    input wire logic        ext_flag_o,
    input wire logic        int_allow_o,
    input wire logic [3:0]  out_pin_o,
    input wire logic [3:0]  bidir_oe_o,
    input wire logic [3:0]  bidir_pull_o,
    input wire logic [10:0] sup_level_mv_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // writes and steps count only once the latch is clear one cycle later
    sequence s_ext_wr;
        wr_i && addr_i == IRC_ADR_EXT ##1 !init_reset_o;
    endsequence
    sequence s_step;
        step_i ##1 !init_reset_o;
    endsequence
    // requests reach the internal reset two edges after they are seen
    AST_PIN_SETS: assert property ((!reset_n_i) [*3] |-> init_reset_o)
        else $error("pin low did not hold reset");
    AST_SUP_SETS: assert property ((supply_low_i && sup_level_mv_o != 11'h000) [*3]
        |-> init_reset_o)
        else $error("supply low did not hold reset");
    // state held while in reset
    AST_PC_RST: assert property (init_reset_o |-> pc_o == IRC_PC_RST)
        else $error("program counter not at start address in reset");
    AST_FLAGS_RST: assert property (init_reset_o |-> !int_flag_o && !ext_flag_o)
        else $error("flags not cleared in reset");
    AST_MASK_RST: assert property (init_reset_o [*2] |-> !int_allow_o)
        else $error("interrupts allowed in reset");
    AST_PINS_RST: assert property (init_reset_o |-> out_pin_o == IRC_OUT_RST
        && bidir_oe_o == IRC_DIR_RST && bidir_pull_o == IRC_PULL_RST)
        else $error("pins not in reset state");
    AST_EXT_SET: assert property (s_ext_wr |-> ext_flag_o)
        else $error("extension write did not set flag");
    AST_PC_STEP: assert property (s_step |-> pc_o == $past(pc_o) + 16'h0001)
        else $error("program counter did not advance");
    AST_ALLOW_CAUSE: assert property ($rose(int_allow_o) |-> $past(wr_i, 2)
        && ($past(addr_i, 2) == IRC_ADR_SPW || $past(addr_i, 2) == IRC_ADR_SPN))
        else $error("interrupts unmasked without a pointer write");
endmodule
bind irc_top irc_top_monitor u_mon (.*);
`default_nettype wire

// ===== testbench.sv
// self-checking bench of the initial-reset controller
`timescale 1ns/100ps
`default_nettype none
module testbench
    import irc_pkg::*;
;
    localparam int AUTH = 8;
    logic mclk_i, srst_i, run, pin_low, supply_low_i, step_i, wr_i, rd_i;
    logic [3:0] key_in_i;
    logic [7:0] addr_i, wdata_i, d, v;
    wire logic reset_n, osc_w, init_rst, int_flag, ext_flag, int_allow;
    wire logic [7:0] rdata;
    wire logic [15:0] pc;
    wire logic [3:0] out_pin, oe, pull;
    wire logic [4:1] opt_rst;
    wire logic [10:0] opt_lvl [4:1];
    int bad_count, comparisons, n;
    int lens [3] = '{45, 54, 70};
    // main clock, 25 ns period
    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    irc_board_model #(.HALF(4)) u_brd (.mclk_i(mclk_i), .run_i(run), .pin_low_i(pin_low),
        .osc_o(osc_w), .reset_n_o(reset_n));
    irc_top #(.KEY_OPT(3), .SUP_OPT(2), .TIME_AUTH(1'b1), .AUTH_TCK(AUTH)) u_dut (
        .mclk_i(mclk_i), .srst_i(srst_i), .reset_n_i(reset_n), .key_in_i(key_in_i),
        .low_speed_osc_i(osc_w), .supply_low_i(supply_low_i), .step_i(step_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
        .init_reset_o(init_rst), .pc_o(pc), .int_flag_o(int_flag), .ext_flag_o(ext_flag),
        .int_allow_o(int_allow), .out_pin_o(out_pin), .bidir_oe_o(oe),
        .bidir_pull_o(pull), .sup_level_mv_o());
    // one small instance per option code, sharing every input
    for (genvar k = 1; k <= 4; k++)
    begin : g_opt
        irc_top #(.KEY_OPT(k), .SUP_OPT(k)) u_opt (.mclk_i(mclk_i), .srst_i(srst_i),
            .reset_n_i(reset_n), .key_in_i(key_in_i), .low_speed_osc_i(osc_w),
            .supply_low_i(supply_low_i), .step_i(step_i), .addr_i(addr_i),
            .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(),
            .init_reset_o(opt_rst[k]), .pc_o(), .int_flag_o(), .ext_flag_o(),
            .int_allow_o(), .out_pin_o(), .bidir_oe_o(), .bidir_pull_o(),
            .sup_level_mv_o(opt_lvl[k]));
    end
    // expected key verdict: selected keys low long enough
    function automatic logic key_hit(input int opt, input logic [3:0] ks, input int tk,
        input bit auth);
        logic [3:0] m;
        m = (opt == 2) ? IRC_KEY_M2 : (opt == 3) ? IRC_KEY_M3 : (opt == 4) ? IRC_KEY_M4 : 4'h0;
        return (m != 4'h0) && ((ks & m) == 4'h0) && (tk >= IRC_FILT_TCK + (auth ? AUTH : 0));
    endfunction
    function automatic logic [10:0] lvl_of(input int opt);
        return (opt == 1) ? 11'(IRC_SUP_MV1) : (opt == 2) ? 11'(IRC_SUP_MV2) :
            (opt == 3) ? 11'(IRC_SUP_MV3) : 11'h000;
    endfunction
    // wide enough for every packed group the bench compares at once
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= dv;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] dv);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 dv = rdata;
    endtask
    // bounded wait for every instance to leave reset
    task automatic wait_rel(input int bound);
        n = 0;
        while ({init_rst, opt_rst} !== 5'h00 && n < bound)
        begin
            cyc(1);
            n++;
        end
        if ({init_rst, opt_rst} !== 5'h00)
        begin
            chk({init_rst, opt_rst}, 5'h00);
            conclude();
        end
    endtask
    task automatic post_chk();
        chk(pc, IRC_PC_RST);
        chk({int_flag, ext_flag, int_allow}, 3'b000);
        chk({out_pin, oe, pull}, {IRC_OUT_RST, IRC_DIR_RST, IRC_PULL_RST});
    endtask
    // keys held low for tk ticks, then let go
    task automatic press(input logic [3:0] ks, input int tk);
        @(posedge mclk_i);
        key_in_i <= ks;
        repeat (tk) @(posedge osc_w);
        cyc(6);
        chk(init_rst, key_hit(3, ks, tk, 1'b1));
        for (int k = 1; k <= 4; k++)
            chk(opt_rst[k], key_hit(k, ks, tk, 1'b0));
        @(posedge mclk_i);
        key_in_i <= 4'hF;
        wait_rel(8400);
    endtask
    // main sequence
    initial
    begin
        {bad_count, comparisons} = '0;
        {srst_i, run, pin_low, supply_low_i, step_i, wr_i, rd_i} = 7'b1000000;
        {key_in_i, addr_i, wdata_i} = {4'hF, 8'h00, 8'h00};
        void'($urandom(32'h3291FE26));
        repeat (5) @(posedge mclk_i);
        srst_i <= 1'b0;
        cyc(2);
        chk(init_rst, 1'b1);
        for (int k = 1; k <= 4; k++)
            chk(opt_lvl[k], lvl_of(k));
        @(posedge mclk_i);
        run <= 1'b1;
        for (n = 0; n < 9000 && init_rst !== 1'b0; n++)
            cyc(1);
        chk(n >= 8000 && n < 9000, 1'b1);
        wait_rel(100);
        post_chk();
        $display("test startup done");
        v = 8'($urandom);
        rd(IRC_ADR_STATUS, d);
        chk(d, 8'h00);
        wr(IRC_ADR_SPW, v);
        chk(int_allow, 1'b0);
        wr(IRC_ADR_SPN, ~v);
        cyc(1);
        chk(int_allow, 1'b1);
        wr(IRC_ADR_SPW, v);
        cyc(1);
        chk(int_allow, 1'b0);
        wr(IRC_ADR_EXT, v);
        chk(ext_flag, 1'b1);
        @(posedge mclk_i);
        step_i <= 1'b1;
        @(posedge mclk_i);
        step_i <= 1'b0;
        #1 chk({ext_flag, pc}, {1'b0, IRC_PC_RST + 16'h0001});
        wr(IRC_ADR_FLAGS, 8'h01);
        wr(IRC_ADR_OUT, v);
        wr(IRC_ADR_DIR, v);
        chk({int_flag, out_pin, oe, pull}, {1'b1, v[3:0], v[3:0], ~v[3:0]});
        rd(8'h1C, d);
        chk(d, 8'h00);
        $display("test registers done");
        @(posedge mclk_i);
        pin_low <= 1'b1;
        cyc(3 + $urandom_range(5));
        chk({init_rst, opt_rst}, 5'h1F);
        @(posedge mclk_i);
        pin_low <= 1'b0;
        wait_rel(8400);
        post_chk();
        $display("test pin done");
        for (int i = 0; i < 3; i++)
            press({1'($urandom), 3'b000}, lens[i]);
        $display("test keys done");
        @(posedge mclk_i);
        supply_low_i <= 1'b1;
        cyc(4);
        chk({init_rst, opt_rst}, 5'b10111);
        @(posedge mclk_i);
        supply_low_i <= 1'b0;
        wait_rel(8400);
        $display("test supply done");
        conclude();
    end
endmodule
`default_nettype wire
